/* rtl/clcd_pkg.sv */
package clcd_pkg;
  // oscillator and bus clock
  localparam int CLK_KHZ     = 40000;
  localparam int OSC_KHZ     = 80;
  localparam int OSC_DIV_DEF = CLK_KHZ / OSC_KHZ;
  // execution times in their own units
  localparam int T_CMD_US    = 125;
  localparam int T_SLOW_US   = 175;
  localparam int T_CLEAR_US  = 1630;
  localparam int T_INIT_MS   = 10;
  localparam int T_BLINK_MS  = 540;
  localparam int TW          = 16;

  function automatic int us2tick(input int t_us);
    return (t_us * OSC_KHZ + 999) / 1000;
  endfunction : us2tick

  localparam logic [TW-1:0] TK_CMD   = TW'(us2tick(T_CMD_US));
  localparam logic [TW-1:0] TK_SLOW  = TW'(us2tick(T_SLOW_US));
  localparam logic [TW-1:0] TK_CLEAR = TW'(us2tick(T_CLEAR_US));
  localparam int INIT_TICKS_DEF      = T_INIT_MS * OSC_KHZ;
  localparam int BLINK_HALF_DEF      = T_BLINK_MS * OSC_KHZ / 2;

  // instruction opcode bits, highest set bit selects the instruction
  localparam int CMD_DD_BIT   = 7;
  localparam int CMD_CG_BIT   = 6;
  localparam int CMD_FN_BIT   = 5;
  localparam int CMD_SH_BIT   = 4;
  localparam int CMD_DC_BIT   = 3;
  localparam int CMD_EM_BIT   = 2;
  localparam int CMD_HOME_BIT = 1;
  localparam int CMD_CLR_BIT  = 0;
  // fields inside instructions
  localparam int FN_WIDTH_BIT = 4;
  localparam int FN_ONE_BIT   = 3;
  localparam int SH_SC_BIT    = 3;
  localparam int SH_RL_BIT    = 2;
  localparam int DC_D_BIT     = 2;
  localparam int DC_C_BIT     = 1;
  localparam int DC_B_BIT     = 0;
  localparam int EM_ID_BIT    = 1;
  localparam int EM_S_BIT     = 0;

  // display-data address map
  localparam logic [6:0] LINE1_BASE = 7'h00;
  localparam logic [6:0] LINE1_LAST = 7'h0B;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h4B;
  localparam logic [3:0] LINE_LEN   = 4'hC;
  localparam int DD_DEPTH           = 24;
  localparam int CG_DEPTH           = 32;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  localparam logic [4:0] CURSOR_DOTS = 5'h1F;

  // queue word: {register select, read step, byte}
  localparam int FW     = 10;
  localparam int FW_RS  = 9;
  localparam int FW_RD  = 8;

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_WAIT} clcd_state_type;
endpackage : clcd_pkg

/* rtl/clcd_fifo.sv */
`timescale 1ns/100ps
module clcd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= ptr_inc(wp_r);
      end
      if (pop) begin
        rp_r <= ptr_inc(rp_r);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : clcd_fifo

/* rtl/clcd_ctrl.sv */
`timescale 1ns/100ps
// Overview of operation
// - cursor is five dots on row eight
// - blink toggles cursor cell every half period
// - bit four alone decodes as shift command
// - cursor runs from line one into two
// - display shift moves both lines, each wraps
// - display-only shift keeps address counter
// - selector and direction pick four shift kinds
// - function set needs bit three; width bit
// - narrow bus moves each byte twice
// - serial host ignores the width bit
// - pattern address load selects pattern ram
// - display address load selects display ram
// - display addresses 00-0B and 40-4B only
// - status read gives busy and counter
// - busy while a command runs or entries are queued
// - display write stores byte, steps, shifts
// - pattern write stores five bits, steps
// - data read returns selected ram contents
// - display read steps counter, never shifts
// - power-up bus is eight bits wide
// - narrow bus: upper nibble first, both directions
// - entry direction steps counter up or down
module clcd_ctrl
  import clcd_pkg::*;
#(
  parameter int OSC_DIV    = OSC_DIV_DEF,
  parameter int INIT_TICKS = INIT_TICKS_DEF,
  parameter int BLINK_HALF = BLINK_HALF_DEF,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       serial_sel,
  input  wire logic       register_select,
  input  wire logic       read_not_write,
  input  wire logic       enable,
  input  wire logic [7:0] db_in,
  output logic      [7:0] db_out,
  output logic            db_oe,
  output logic            busy_flag,
  output logic            wr_ready,
  output logic            display_on,
  input  wire logic       scan_line,
  input  wire logic [3:0] scan_col,
  input  wire logic [2:0] scan_row,
  output logic      [7:0] char_code,
  output logic      [4:0] cursor_dots,
  output logic            blank_cell
);
  clcd_state_type state_r;
  logic [TW-1:0] div_r;
  logic          tick_r;
  logic [TW-1:0] wait_r;
  logic [TW-1:0] blk_cnt_r;
  logic          blink_ph_r;
  logic          en_d_r;
  logic          width8_r;
  logic          nib_lo_r;
  logic [3:0]    hi_nib_r;
  logic [7:0]    rd_snap_r;
  logic [7:0]    db_out_r;
  logic [6:0]    ac_r;
  logic          cg_sel_r;
  logic          inc_r;
  logic          shift_en_r;
  logic [3:0]    shift_r;
  logic          disp_on_r;
  logic          cursor_on_r;
  logic          blink_on_r;
  logic          fetch_r;
  logic [7:0]    rd_latch_r;
  logic [7:0]    dd_r [DD_DEPTH];
  logic [4:0]    cg_r [CG_DEPTH];
  logic [7:0]    char_r;
  logic [4:0]    cdots_r;
  logic          blank_r;
  logic          en_rise;
  logic          wide;
  logic          push;
  logic [FW-1:0] push_w;
  logic          q_vld;
  logic [FW-1:0] q_w;
  logic          take;
  logic [7:0]    d;
  logic          do_wr, do_rd, do_dd, do_cg, do_fn, do_sh;
  logic          do_dc, do_em, do_home, do_clr;
  logic [TW-1:0] tk_nxt;
  logic [7:0]    rd_val;
  logic [6:0]    scan_addr;

  function automatic logic dd_ok(input logic [6:0] a);
    return (a[5:4] == 2'b00) && (a[3:0] < LINE_LEN);
  endfunction : dd_ok

  function automatic logic [4:0] dd_idx(input logic [6:0] a);
    return a[6] ? 5'(a[3:0]) + 5'(LINE_LEN) : 5'(a[3:0]);
  endfunction : dd_idx

  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                         input logic cg);
    logic [6:0] r;
    r = a;
    if (cg) begin
      r = {2'b00, up ? a[4:0] + 5'h01 : a[4:0] - 5'h01};
    end else if (up) begin
      r = (a == LINE1_LAST) ? LINE2_BASE : (a == LINE2_LAST) ? LINE1_BASE : a + 7'h01;
    end else begin
      r = (a == LINE1_BASE) ? LINE2_LAST : (a == LINE2_BASE) ? LINE1_LAST : a - 7'h01;
    end
    return r;
  endfunction : ac_step

  function automatic logic [3:0] sh_step(input logic [3:0] s, input logic left);
    if (left) begin
      return (s == LINE_LEN - 4'h1) ? 4'h0 : s + 4'h1;
    end
    return (s == 4'h0) ? LINE_LEN - 4'h1 : s - 4'h1;
  endfunction : sh_step

  function automatic logic [7:0] ram_rd(input logic [6:0] a, input logic cg,
                                        input logic [7:0] dd [DD_DEPTH],
                                        input logic [4:0] cgm [CG_DEPTH]);
    if (cg) begin
      return {3'b000, cgm[a[4:0]]};
    end
    return dd_ok(a) ? dd[dd_idx(a)] : 8'h00;
  endfunction : ram_rd

  // host bus side: bytes are assembled and queued, not executed here
  assign en_rise = enable & ~en_d_r;
  assign wide    = width8_r | serial_sel;
  assign rd_val  = register_select ? rd_latch_r : {busy_flag, ac_r};
  assign db_oe   = enable & read_not_write;
  assign db_out  = db_out_r;

  always_comb begin
    push   = 1'b0;
    push_w = {register_select, read_not_write, db_in};
    if (en_rise && !read_not_write) begin
      push = wide | nib_lo_r;
      if (!wide) begin
        push_w[7:0] = {hi_nib_r, db_in[7:4]};
      end
    end else if (en_rise && register_select) begin
      push = wide | nib_lo_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d_r    <= 1'b0;
      nib_lo_r  <= 1'b0;
      hi_nib_r  <= 4'h0;
      rd_snap_r <= 8'h00;
      db_out_r  <= 8'h00;
    end else begin
      en_d_r <= enable;
      if (wide) begin
        nib_lo_r <= 1'b0;
        if (en_rise && read_not_write) begin
          db_out_r <= rd_val;
        end
      end else if (en_rise) begin
        nib_lo_r <= ~nib_lo_r;
        if (!nib_lo_r) begin
          hi_nib_r  <= db_in[7:4];
          rd_snap_r <= rd_val;
          db_out_r  <= {rd_val[7:4], 4'h0};
        end else begin
          db_out_r <= {rd_snap_r[3:0], 4'h0};
        end
      end
    end
  end

  // queue between bus and executor; a full queue drops the byte
  clcd_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_data   (push_w),
    .in_ready  (wr_ready),
    .out_valid (q_vld),
    .out_data  (q_w),
    .out_ready (take)
  );

  // executor takes one entry only when idle
  assign take      = (state_r == ST_IDLE) & q_vld;
  assign busy_flag = (state_r != ST_IDLE) | q_vld;
  assign d         = q_w[7:0];

  always_comb begin
    {do_wr, do_rd, do_dd, do_cg, do_fn} = 5'b0;
    {do_sh, do_dc, do_em, do_home, do_clr} = 5'b0;
    tk_nxt = TK_CMD;
    if (take) begin
      if (q_w[FW_RS]) begin
        do_wr = ~q_w[FW_RD];
        do_rd = q_w[FW_RD];
        tk_nxt = q_w[FW_RD] ? TK_SLOW : TK_CMD;
      end else if (d[CMD_DD_BIT]) begin
        do_dd = 1'b1;
      end else if (d[CMD_CG_BIT]) begin
        do_cg = 1'b1;
      end else if (d[CMD_FN_BIT]) begin
        do_fn = d[FN_ONE_BIT];
      end else if (d[CMD_SH_BIT]) begin
        do_sh  = 1'b1;
        tk_nxt = TK_SLOW;
      end else if (d[CMD_DC_BIT]) begin
        do_dc = 1'b1;
      end else if (d[CMD_EM_BIT]) begin
        do_em = 1'b1;
      end else if (d[CMD_HOME_BIT]) begin
        do_home = 1'b1;
      end else if (d[CMD_CLR_BIT]) begin
        do_clr = 1'b1;
        tk_nxt = TK_CLEAR;
      end
    end
  end

  // internal oscillator tick and busy timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TW'(OSC_DIV - 1));
      div_r  <= (div_r == TW'(OSC_DIV - 1)) ? '0 : div_r + TW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
      wait_r  <= TW'(INIT_TICKS);
    end else begin
      case (state_r)
        ST_INIT, ST_WAIT: begin
          if (wait_r == '0) begin
            state_r <= ST_IDLE;
          end else if (tick_r) begin
            wait_r <= wait_r - TW'(1);
          end
        end
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_WAIT;
            wait_r  <= tk_nxt;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // address counter and ram selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_r     <= LINE1_BASE;
      cg_sel_r <= 1'b0;
    end else if (do_dd) begin
      ac_r     <= d[6:0];
      cg_sel_r <= 1'b0;
    end else if (do_cg) begin
      ac_r     <= {2'b00, d[4:0]};
      cg_sel_r <= 1'b1;
    end else if (do_clr || do_home) begin
      ac_r     <= LINE1_BASE;
      cg_sel_r <= 1'b0;
    end else if (do_wr || do_rd) begin
      ac_r <= ac_step(ac_r, inc_r, cg_sel_r);
    end else if (do_sh && !d[SH_SC_BIT]) begin
      ac_r <= ac_step(ac_r, d[SH_RL_BIT], cg_sel_r);
    end
  end

  // display shift, shared by both lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 4'h0;
    end else if (do_clr || do_home) begin
      shift_r <= 4'h0;
    end else if (do_sh && d[SH_SC_BIT]) begin
      shift_r <= sh_step(shift_r, ~d[SH_RL_BIT]);
    end else if (do_wr && shift_en_r && !cg_sel_r) begin
      shift_r <= sh_step(shift_r, inc_r);
    end
  end

  // mode and attribute bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width8_r    <= 1'b1;
      inc_r       <= 1'b1;
      shift_en_r  <= 1'b0;
      disp_on_r   <= 1'b0;
      cursor_on_r <= 1'b0;
      blink_on_r  <= 1'b0;
    end else begin
      if (do_fn && !serial_sel) begin
        width8_r <= d[FN_WIDTH_BIT];
      end
      if (do_em) begin
        inc_r      <= d[EM_ID_BIT];
        shift_en_r <= d[EM_S_BIT];
      end else if (do_clr) begin
        inc_r <= 1'b1;
      end
      if (do_dc) begin
        disp_on_r   <= d[DC_D_BIT];
        cursor_on_r <= d[DC_C_BIT];
        blink_on_r  <= d[DC_B_BIT];
      end
    end
  end

  // ram storage; out-of-map display addresses are not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DD_DEPTH; i++) begin
        dd_r[i] <= SPACE_CODE;
      end
      for (int i = 0; i < CG_DEPTH; i++) begin
        cg_r[i] <= 5'h00;
      end
    end else if (do_clr) begin
      for (int i = 0; i < DD_DEPTH; i++) begin
        dd_r[i] <= SPACE_CODE;
      end
    end else if (do_wr && cg_sel_r) begin
      cg_r[ac_r[4:0]] <= d[4:0];
    end else if (do_wr && dd_ok(ac_r)) begin
      dd_r[dd_idx(ac_r)] <= d;
    end
  end

  // read latch is refreshed only after address set, cursor shift or read,
  // so a read right after a write returns stale data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_r    <= 1'b0;
      rd_latch_r <= 8'h00;
    end else begin
      fetch_r <= do_dd | do_cg | do_rd | (do_sh & ~d[SH_SC_BIT]);
      if (fetch_r) begin
        rd_latch_r <= ram_rd(ac_r, cg_sel_r, dd_r, cg_r);
      end
    end
  end

  // blink phase from the oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt_r  <= '0;
      blink_ph_r <= 1'b0;
    end else if (tick_r) begin
      if (blk_cnt_r == TW'(BLINK_HALF - 1)) begin
        blk_cnt_r  <= '0;
        blink_ph_r <= ~blink_ph_r;
      end else begin
        blk_cnt_r <= blk_cnt_r + TW'(1);
      end
    end
  end

  // scan port: visible column plus shift, wrapped inside the line
  always_comb begin
    scan_addr = {scan_line, 2'b00, scan_col + shift_r};
    if (5'(scan_col) + 5'(shift_r) >= 5'(LINE_LEN)) begin
      scan_addr[3:0] = scan_col + shift_r - LINE_LEN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_r  <= 8'h00;
      cdots_r <= 5'h00;
      blank_r <= 1'b0;
    end else begin
      char_r  <= dd_r[dd_idx(scan_addr)];
      cdots_r <= (cursor_on_r && scan_addr == ac_r && scan_row == CURSOR_ROW)
                 ? CURSOR_DOTS : 5'h00;
      blank_r <= blink_on_r & blink_ph_r & (scan_addr == ac_r);
    end
  end

  assign char_code   = char_r;
  assign cursor_dots = cdots_r;
  assign blank_cell  = blank_r;
  assign display_on  = disp_on_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  cursor_row_a: assert property (cursor_dots != 5'h00 |->
      $past(cursor_on_r) && $past(scan_row) == CURSOR_ROW)
    else $error("cursor drawn off its row");
  blink_rate_a: assert property ($changed(blink_ph_r) |->
      $past(tick_r) && $past(blk_cnt_r) == TW'(BLINK_HALF - 1))
    else $error("blink toggled early");
  dshift_ac_a: assert property (do_sh && d[SH_SC_BIT] |=> $stable(ac_r))
    else $error("display shift moved counter");
  line_wrap_a: assert property (do_wr && !cg_sel_r && inc_r
      && ac_r == LINE1_LAST |=> ac_r == LINE2_BASE)
    else $error("cursor did not enter line two");
  shift_range_a: assert property (shift_r < LINE_LEN)
    else $error("shift out of line");
  dd_load_a: assert property (do_dd |=> ac_r == $past(d[6:0]) && !cg_sel_r)
    else $error("display address not loaded");
  cg_load_a: assert property (do_cg |=> ac_r[4:0] == $past(d[4:0]) && cg_sel_r)
    else $error("pattern address not loaded");
  busy_hold_a: assert property (take |=> busy_flag [*2])
    else $error("busy dropped during execution");
  status_rd_a: assert property (en_rise && read_not_write && !register_select
      && wide |=> db_out == {$past(busy_flag), $past(ac_r)})
    else $error("status read wrong");
  rd_noshift_a: assert property (do_rd |=> $stable(shift_r))
    else $error("read shifted display");
  width_set_a: assert property (do_fn |=> width8_r ==
      ($past(serial_sel) ? $past(width8_r) : $past(d[FN_WIDTH_BIT])))
    else $error("width bit not handled");

  clear_c: cover property (do_clr ##[1:600] state_r == ST_IDLE);
  narrow_c: cover property (do_fn && !d[FN_WIDTH_BIT] ##[1:300] push && !wide);
  full_c: cover property (!wr_ready);
  read_c: cover property (do_dd ##[1:300] do_rd);
endmodule : clcd_ctrl

/* sim/clcd_host_model.sv */
`timescale 1ns/100ps
module clcd_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] db_out,
  output logic            register_select,
  output logic            read_not_write,
  output logic            enable,
  output logic      [7:0] db_in
);
  logic narrow = 1'b0;
  logic hung   = 1'b0;

  initial begin
    register_select = 1'b0;
    read_not_write  = 1'b0;
    enable          = 1'b0;
    db_in           = 8'hFF;
  end

  // one enable pulse; released lines sit at the pull-up level, not the last value
  task automatic strobe(input logic rs, input logic rnw, input logic [7:0] d,
                        output logic [7:0] rd);
    @(posedge clk);
    register_select <= rs;
    read_not_write  <= rnw;
    db_in           <= rnw ? 8'hFF : d;
    enable          <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    enable <= 1'b0;
    db_in  <= 8'hFF;
    #1 rd = db_out;
  endtask : strobe

  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d,
                      output logic [7:0] rd);
    logic [7:0] hi;
    logic [7:0] lo;
    if (narrow) begin
      strobe(rs, rnw, {d[7:4], 4'hF}, hi);
      strobe(rs, rnw, {d[3:0], 4'hF}, lo);
      rd = {hi[7:4], lo[7:4]};
    end else begin
      strobe(rs, rnw, d, rd);
    end
  endtask : xfer

  // bounded poll so a stuck busy surfaces instead of hanging
  task automatic wait_idle();
    logic [7:0] st;
    st = 8'hFF;
    for (int k = 0; k < 300 && st[7] !== 1'b0; k++) begin
      xfer(1'b0, 1'b1, 8'hFF, st);
    end
    if (st[7] !== 1'b0) hung = 1'b1;
  endtask : wait_idle
endmodule : clcd_host_model

/* sim/tb_clcd_ctrl.sv */
`timescale 1ns/100ps
module tb_clcd_ctrl
  import clcd_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n;
  logic       serial_sel;
  logic       register_select;
  logic       read_not_write;
  logic       enable;
  logic [7:0] db_in;
  logic [7:0] db_out;
  logic       db_oe;
  logic       busy_flag;
  logic       wr_ready;
  logic       display_on;
  logic       scan_line;
  logic [3:0] scan_col;
  logic [2:0] scan_row;
  logic [7:0] char_code;
  logic [4:0] cursor_dots;
  logic       blank_cell;
  logic [7:0] r;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [6:0] ac;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         n;

  always #12.5 clk = ~clk;

  clcd_ctrl #(.OSC_DIV(4), .INIT_TICKS(3), .BLINK_HALF(4), .FIFO_DEPTH(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .serial_sel(serial_sel),
    .register_select(register_select), .read_not_write(read_not_write),
    .enable(enable), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .busy_flag(busy_flag), .wr_ready(wr_ready), .display_on(display_on),
    .scan_line(scan_line), .scan_col(scan_col), .scan_row(scan_row),
    .char_code(char_code), .cursor_dots(cursor_dots), .blank_cell(blank_cell));

  clcd_host_model host_u (
    .clk(clk), .db_out(db_out), .register_select(register_select),
    .read_not_write(read_not_write), .enable(enable), .db_in(db_in));

  // the device must drive the bus for the whole of every read strobe
  always @(posedge clk) begin
    if (enable === 1'b1 && read_not_write === 1'b1) begin
      check("drive enable", 8'(db_oe), 8'h01);
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic done(input string name);
    $display("test %s finished", name);
    if (host_u.hung) begin
      n_fail++;
      close_out();
    end
  endtask : done

  task automatic cmd(input logic [7:0] c);
    host_u.wait_idle();
    host_u.xfer(1'b0, 1'b0, c, r);
  endtask : cmd

  task automatic wr(input logic [7:0] d);
    host_u.wait_idle();
    host_u.xfer(1'b1, 1'b0, d, r);
  endtask : wr

  task automatic rdd();
    host_u.wait_idle();
    host_u.xfer(1'b1, 1'b1, 8'hFF, r);
  endtask : rdd

  task automatic stat(input string what, input logic [6:0] exp);
    host_u.wait_idle();
    host_u.xfer(1'b0, 1'b1, 8'hFF, r);
    check(what, r, {1'b0, exp});
  endtask : stat

  task automatic scan(input logic ln, input logic [3:0] col, input logic [2:0] row);
    @(posedge clk);
    scan_line <= ln;
    scan_col  <= col;
    scan_row  <= row;
    repeat (2) @(posedge clk);
    #1;
  endtask : scan

  // counter step with the line-to-line wrap of the display map
  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    if (up) return (a == 7'h0B) ? 7'h40 : (a == 7'h4B) ? 7'h00 : a + 7'h01;
    return (a == 7'h00) ? 7'h4B : (a == 7'h40) ? 7'h0B : a - 7'h01;
  endfunction : step

  initial begin
    rst_n      = 1'b0;
    serial_sel = 1'b0;
    scan_line  = 1'b0;
    scan_col   = 4'h0;
    scan_row   = 3'h0;
    void'($urandom(58065));
    repeat (9) @(posedge clk);
    #1;
    check("reset busy", 8'(busy_flag), 8'h01);
    check("reset ready", 8'(wr_ready), 8'h01);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("init busy", 8'(busy_flag), 8'h01);
    cmd(8'h38);
    cmd(8'h0F);
    cmd(8'h06);
    host_u.wait_idle();
    check("display on", 8'(display_on), 8'h01);
    done("init");
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    cmd(8'h8A);
    stat("dd address", 7'h0A);
    wr(d0);
    wr(d1);
    stat("line wrap", step(step(7'h0A, 1'b1), 1'b1));
    cmd(8'h8A);
    rdd();
    check("dd read 0", r, d0);
    rdd();
    check("dd read 1", r, d1);
    stat("read step", 7'h40);
    cmd(8'h04);
    cmd(8'hC0);
    wr(d1);
    stat("dec wrap", step(7'h40, 1'b0));
    cmd(8'h06);
    done("ddram");
    for (int i = 0; i < 4; i++) begin
      cmd(8'h85);
      cmd(8'h10 | 8'(i << 2) | 8'($urandom() & 3));
      stat("shift", i[1] ? 7'h05 : step(7'h05, i[0]));
    end
    cmd(8'h18);
    scan(1'b1, 4'hB, 3'h0);
    check("line 2 wrap", char_code, d1);
    scan(1'b0, 4'h9, 3'h0);
    check("line 1 shift", char_code, d0);
    cmd(8'h1C);
    cmd(8'hC0);
    scan(1'b1, 4'h0, 3'h7);
    check("cursor row", 8'(cursor_dots), 8'(CURSOR_DOTS));
    scan(1'b1, 4'h0, 3'h6);
    check("other row", 8'(cursor_dots), 8'h00);
    n = 0;
    // half period is 16 clocks here, so any 64-clock window holds 32 blank ones
    repeat (64) begin
      @(posedge clk);
      #1 n += int'(blank_cell === 1'b1);
    end
    check("blink duty", 8'(n), 8'h20);
    done("shift cursor blink");
    d0 = 8'($urandom());
    ac = 7'($urandom() & 31);
    cmd(8'h40 | {1'b0, ac});
    wr(d0);
    stat("cg step", (ac + 7'h01) & 7'h1F);
    cmd(8'h40 | {1'b0, ac});
    rdd();
    check("cg read", {3'h0, r[4:0]}, {3'h0, d0[4:0]});
    cmd(8'h80);
    n = 0;
    while (wr_ready === 1'b1 && n < 8) begin
      host_u.xfer(1'b0, 1'b0, 8'h14, r);
      n++;
    end
    check("queue full", 8'(wr_ready), 8'h00);
    check("queue depth", 8'(n), 8'h04);
    host_u.xfer(1'b0, 1'b0, 8'h14, r);
    stat("queued shifts", 7'h04);
    done("cg and queue");
    @(posedge clk);
    serial_sel <= 1'b1;
    cmd(8'h28);
    @(posedge clk);
    serial_sel <= 1'b0;
    stat("serial width", 7'h04);
    host_u.wait_idle();
    host_u.strobe(1'b0, 1'b0, 8'h2F, r);
    host_u.narrow = 1'b1;
    cmd(8'h28);
    cmd(8'hC3);
    stat("nibble status", 7'h43);
    wr(d1);
    cmd(8'h07);
    cmd(8'hC3);
    rdd();
    check("nibble read", r, d1);
    scan(1'b1, 4'h3, 3'h0);
    check("read no shift", char_code, d1);
    wr(d0);
    scan(1'b1, 4'h3, 3'h0);
    check("entry shift", char_code, d0);
    cmd(8'h02);
    stat("home", 7'h00);
    scan(1'b1, 4'h3, 3'h0);
    check("home shift", char_code, d1);
    cmd(8'h01);
    stat("clear", 7'h00);
    scan(1'b1, 4'h3, 3'h0);
    check("clear ram", char_code, SPACE_CODE);
    done("narrow bus");
    close_out();
  end
endmodule : tb_clcd_ctrl
